/* verilog/eeprom_cmd_pkg.sv */
// constants and types shared by the eeprom command decode block
package eeprom_cmd_pkg;

   // command byte field positions
   localparam int DIR_BIT = 0;
   localparam int USE_ADDR_BIT = 1;
   localparam int MISSING_ACK_BIT = 3;
   localparam int FRAMING_BIT = 5;

   // direction encoding
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;

   // byte positions after the slave address
   localparam logic [2:0] POS_CODE = 3'h0;
   localparam logic [2:0] POS_LEN = 3'h1;
   localparam logic [2:0] POS_CMD = 3'h2;
   localparam logic [2:0] POS_ADDR = 3'h3;
   localparam logic [2:0] POS_OFFL = 3'h4;
   localparam logic [2:0] POS_OFFH = 3'h5;
   localparam logic [2:0] POS_DATA = 3'h6;
   localparam logic [2:0] POS_DONE = 3'h7;

   // bytes that follow the length byte on a read-back: command, data
   localparam logic [7:0] REPLY_LEN = 8'h02;
   localparam logic [7:0] COUNT_STEP = 8'h01;

   // flag reset value and number of flags
   localparam logic FLAG_RST = 1'b0;
   localparam int NUM_FLAGS = 2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACCESS = 2'b01,
      ST_REPLY = 2'b11
   } core_state_t;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] addr;
      logic [7:0] offl;
      logic [7:0] offh;
      logic [7:0] data;
   } req_word_t;

   typedef struct packed {
      logic [7:0] cmd;
      logic [7:0] data;
   } reply_word_t;

endpackage : eeprom_cmd_pkg

/* verilog/word_xfer_if.sv */
// word transfer between two clock domains
`timescale 1ns/1ps
`default_nettype none
interface word_xfer_if #(parameter int W = 8);
   logic s_valid;
   logic [W-1:0] s_data;
   logic s_busy;
   logic d_ready;
   logic d_strobe;
   logic [W-1:0] d_data;
   modport feed (output s_valid, output s_data, input s_busy, output d_ready, input d_strobe, input d_data);
   modport xfer (input s_valid, input s_data, output s_busy, input d_ready, output d_strobe, output d_data);
endinterface : word_xfer_if
`default_nettype wire

/* verilog/sticky_flag_cell.sv */
// sticky error flag, set by event, cleared by writing one
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_cell
   import eeprom_cmd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic set_evt,
   input wire logic clr_cmd,
   input wire logic clr_sts,
   output logic flag
);
   typedef struct packed {
      logic flag;
   } flag_state_t;

   flag_state_t st_ff;
   flag_state_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (clr_cmd || clr_sts) begin
         nxt_st.flag = 1'b0;
      end
      // set wins over a clear in the same cycle
      if (set_evt) begin
         nxt_st.flag = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff.flag <= FLAG_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign flag = st_ff.flag;
endmodule : sticky_flag_cell
`default_nettype wire

/* verilog/cdc_word_handshake.sv */
// toggle handshake carrying a word between two clocks
`timescale 1ns/1ps
`default_nettype none
module cdc_word_handshake
   import eeprom_cmd_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic src_clk,
   input wire logic dst_clk,
   input wire logic rst_n,
   word_xfer_if.xfer port
);
   if (W < 1) begin : g_bad_width
      $error("word width must be at least one bit");
   end

   typedef struct packed {
      logic req_tgl;
      logic ack_s1;
      logic ack_s2;
      logic [W-1:0] data;
   } src_state_t;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic req_seen;
      logic strobe;
      logic [W-1:0] data;
   } dst_state_t;

   src_state_t src_ff;
   src_state_t nxt_src;
   dst_state_t dst_ff;
   dst_state_t nxt_dst;

   // source side: word held stable until the toggle comes back
   always_comb begin
      nxt_src = src_ff;
      nxt_src.ack_s1 = dst_ff.req_seen;
      nxt_src.ack_s2 = src_ff.ack_s1;
      if (port.s_valid && (src_ff.req_tgl == src_ff.ack_s2)) begin
         nxt_src.req_tgl = ~src_ff.req_tgl;
         nxt_src.data = port.s_data;
      end
   end

   // destination side: capture only while the receiver is ready
   always_comb begin
      nxt_dst = dst_ff;
      nxt_dst.req_s1 = src_ff.req_tgl;
      nxt_dst.req_s2 = dst_ff.req_s1;
      nxt_dst.strobe = 1'b0;
      if ((dst_ff.req_s2 != dst_ff.req_seen) && port.d_ready) begin
         nxt_dst.req_seen = dst_ff.req_s2;
         nxt_dst.strobe = 1'b1;
         nxt_dst.data = src_ff.data;
      end
   end

   always_ff @(posedge src_clk or negedge rst_n) begin
      if (!rst_n) begin
         src_ff <= '0;
      end else begin
         src_ff <= nxt_src;
      end
   end

   always_ff @(posedge dst_clk or negedge rst_n) begin
      if (!rst_n) begin
         dst_ff <= '0;
      end else begin
         dst_ff <= nxt_dst;
      end
   end

   assign port.s_busy = src_ff.req_tgl != src_ff.ack_s2;
   assign port.d_strobe = dst_ff.strobe;
   assign port.d_data = dst_ff.data;
endmodule : cdc_word_handshake
`default_nettype wire

/* verilog/eeprom_cmd_decode.sv */
// eeprom access command decode with sticky master-side error flags
// Notes on behaviour
// - command bit 0 clear means eeprom write, set means eeprom read.
// - command bit 1 set selects the request's address over the default one.
// - unexpected nack on the eeprom access sets the missing-ack flag, bit 3.
// - missing-ack flag clears on a written one, same as status register copy.
// - misplaced start or stop on the eeprom access sets framing flag, bit 5.
// - framing flag clears on a written one, same as status register copy.
// - request bytes: code, optional length, command, address, offsets low/high, data.
// - length byte only in block transfers, counts following bytes including status.
`timescale 1ns/1ps
`default_nettype none
module eeprom_cmd_decode
   import eeprom_cmd_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic link_frame_start,
   input wire logic link_block_mode,
   input wire logic link_byte_valid,
   input wire logic [7:0] link_byte,
   input wire logic link_frame_stop,
   output logic link_reply_valid,
   output logic [7:0] link_reply_len,
   output logic [7:0] link_reply_cmd,
   output logic [7:0] link_reply_data,
   output logic link_frame_bad,
   output logic link_busy,
   input wire logic [6:0] default_memory_device_address,
   input wire logic sts_clear_missing_ack,
   input wire logic sts_clear_framing,
   output logic ee_req,
   output logic ee_write,
   output logic [6:0] ee_dev_addr,
   output logic [15:0] ee_offset,
   output logic [7:0] ee_wdata,
   input wire logic ee_done,
   input wire logic [7:0] ee_rdata,
   input wire logic ee_nack,
   input wire logic ee_framing,
   output logic missing_ack_flag,
   output logic framing_fault_flag
);

   function automatic logic is_read(input logic [7:0] cmd);
      is_read = cmd[DIR_BIT] == DIR_READ;
   endfunction : is_read

   function automatic logic [7:0] build_reply_cmd(input logic [7:0] cmd, input logic miss, input logic fram);
      logic [7:0] r;
      r = 8'h00;
      r[DIR_BIT] = cmd[DIR_BIT];
      r[USE_ADDR_BIT] = cmd[USE_ADDR_BIT];
      r[MISSING_ACK_BIT] = miss;
      r[FRAMING_BIT] = fram;
      build_reply_cmd = r;
   endfunction : build_reply_cmd

   typedef struct packed {
      logic active;
      logic block;
      logic [2:0] pos;
      logic [7:0] len;
      logic [7:0] cnt;
      logic overrun;
      req_word_t req;
      logic send;
      logic bad;
      logic busy;
      logic reply_valid;
      logic [7:0] reply_len;
      reply_word_t reply;
   } link_state_t;

   typedef struct packed {
      core_state_t st;
      logic ee_req;
      logic ee_write;
      logic [6:0] ee_dev_addr;
      logic [15:0] ee_offset;
      logic [7:0] ee_wdata;
      logic [7:0] cmd;
      logic [7:0] rdata;
      logic rep_send;
      reply_word_t rep;
   } core_state_ff_t;

   link_state_t lk_ff;
   link_state_t nxt_lk;
   core_state_ff_t co_ff;
   core_state_ff_t nxt_co;

   word_xfer_if #(.W($bits(req_word_t))) req_x ();
   word_xfer_if #(.W($bits(reply_word_t))) rep_x ();

   logic [NUM_FLAGS-1:0] flag_set;
   logic [NUM_FLAGS-1:0] flag_clr_cmd;
   logic [NUM_FLAGS-1:0] flag_clr_sts;
   logic [NUM_FLAGS-1:0] flag_val;
   logic frame_ok;
   req_word_t in_req;

   // request word from link clock into core clock
   cdc_word_handshake #(.W($bits(req_word_t))) u_req_xfer (
      .src_clk(link_clk),
      .dst_clk(core_clk),
      .rst_n(rst_n),
      .port(req_x.xfer)
   );

   // read-back word from core clock into link clock
   cdc_word_handshake #(.W($bits(reply_word_t))) u_rep_xfer (
      .src_clk(core_clk),
      .dst_clk(link_clk),
      .rst_n(rst_n),
      .port(rep_x.xfer)
   );

   // link clock side

   // block frames must match their length byte
   always_comb begin
      frame_ok = !lk_ff.overrun && !lk_ff.busy && (lk_ff.pos >= POS_DATA);
      if (!is_read(lk_ff.req.cmd) && (lk_ff.pos != POS_DONE)) begin
         frame_ok = 1'b0;
      end
      if (lk_ff.block && (lk_ff.cnt != lk_ff.len)) begin
         frame_ok = 1'b0;
      end
   end

   always_comb begin
      nxt_lk = lk_ff;
      nxt_lk.send = 1'b0;
      nxt_lk.bad = 1'b0;
      nxt_lk.reply_valid = 1'b0;
      nxt_lk.busy = req_x.s_busy;
      if (link_frame_start) begin
         nxt_lk.active = 1'b1;
         nxt_lk.block = link_block_mode;
         nxt_lk.pos = POS_CODE;
         nxt_lk.cnt = 8'h00;
         nxt_lk.overrun = 1'b0;
      end else if (link_byte_valid && lk_ff.active) begin
         if (lk_ff.pos > POS_LEN) begin
            nxt_lk.cnt = lk_ff.cnt + COUNT_STEP;
         end
         // byte order after the slave address
         case (lk_ff.pos)
            POS_CODE: begin
               nxt_lk.pos = lk_ff.block ? POS_LEN : POS_CMD;
            end
            POS_LEN: begin
               nxt_lk.len = link_byte;
               nxt_lk.pos = POS_CMD;
            end
            POS_CMD: begin
               nxt_lk.req.cmd = link_byte;
               nxt_lk.pos = POS_ADDR;
            end
            POS_ADDR: begin
               nxt_lk.req.addr = link_byte;
               nxt_lk.pos = POS_OFFL;
            end
            POS_OFFL: begin
               nxt_lk.req.offl = link_byte;
               nxt_lk.pos = POS_OFFH;
            end
            POS_OFFH: begin
               nxt_lk.req.offh = link_byte;
               nxt_lk.pos = POS_DATA;
            end
            POS_DATA: begin
               nxt_lk.req.data = link_byte;
               nxt_lk.pos = POS_DONE;
            end
            default: begin
               nxt_lk.overrun = 1'b1;
            end
         endcase
      end else if (link_frame_stop && lk_ff.active) begin
         nxt_lk.active = 1'b0;
         nxt_lk.send = frame_ok;
         nxt_lk.bad = !frame_ok;
      end
      // read-back carries its own length byte
      if (rep_x.d_strobe) begin
         nxt_lk.reply_valid = 1'b1;
         nxt_lk.reply_len = REPLY_LEN;
         nxt_lk.reply = rep_x.d_data;
      end
   end

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         lk_ff <= '0;
      end else begin
         lk_ff <= nxt_lk;
      end
   end

   assign req_x.s_valid = lk_ff.send;
   assign req_x.s_data = lk_ff.req;
   assign rep_x.d_ready = 1'b1;

   // core clock side

   assign in_req = req_x.d_data;
   assign req_x.d_ready = co_ff.st == ST_IDLE;

   always_comb begin
      nxt_co = co_ff;
      nxt_co.ee_req = 1'b0;
      nxt_co.rep_send = 1'b0;
      case (co_ff.st)
         ST_IDLE: begin
            if (req_x.d_strobe) begin
               nxt_co.cmd = in_req.cmd;
               nxt_co.ee_write = !is_read(in_req.cmd);
               // given address taken from bits 7:1
               nxt_co.ee_dev_addr = in_req.cmd[USE_ADDR_BIT] ? in_req.addr[7:1] : default_memory_device_address;
               nxt_co.ee_offset = {in_req.offh, in_req.offl};
               nxt_co.ee_wdata = in_req.data;
               nxt_co.ee_req = 1'b1;
               nxt_co.st = ST_ACCESS;
            end
         end
         ST_ACCESS: begin
            if (ee_done) begin
               nxt_co.rdata = ee_rdata;
               nxt_co.st = co_ff.ee_write ? ST_IDLE : ST_REPLY;
            end
         end
         ST_REPLY: begin
            if (!rep_x.s_busy) begin
               nxt_co.rep.cmd = build_reply_cmd(co_ff.cmd, flag_val[0], flag_val[1]);
               nxt_co.rep.data = co_ff.rdata;
               nxt_co.rep_send = 1'b1;
               nxt_co.st = ST_IDLE;
            end
         end
         default: begin
            nxt_co.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         co_ff <= '0;
      end else begin
         co_ff <= nxt_co;
      end
   end

   assign rep_x.s_valid = co_ff.rep_send;
   assign rep_x.s_data = co_ff.rep;

   assign flag_set[0] = ee_nack;
   assign flag_set[1] = ee_framing;
   // one written in the command byte clears
   assign flag_clr_cmd[0] = req_x.d_strobe && in_req.cmd[MISSING_ACK_BIT];
   // one written in the command byte clears
   assign flag_clr_cmd[1] = req_x.d_strobe && in_req.cmd[FRAMING_BIT];
   assign flag_clr_sts[0] = sts_clear_missing_ack;
   assign flag_clr_sts[1] = sts_clear_framing;

   for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
      sticky_flag_cell u_flag (
         .clk(core_clk),
         .rst_n(rst_n),
         .set_evt(flag_set[i]),
         .clr_cmd(flag_clr_cmd[i]),
         .clr_sts(flag_clr_sts[i]),
         .flag(flag_val[i])
      );
   end

   // registered outputs

   assign link_reply_valid = lk_ff.reply_valid;
   assign link_reply_len = lk_ff.reply_len;
   assign link_reply_cmd = lk_ff.reply.cmd;
   assign link_reply_data = lk_ff.reply.data;
   assign link_frame_bad = lk_ff.bad;
   assign link_busy = lk_ff.busy;
   assign ee_req = co_ff.ee_req;
   assign ee_write = co_ff.ee_write;
   assign ee_dev_addr = co_ff.ee_dev_addr;
   assign ee_offset = co_ff.ee_offset;
   assign ee_wdata = co_ff.ee_wdata;
   assign missing_ack_flag = flag_val[0];
   assign framing_fault_flag = flag_val[1];

endmodule : eeprom_cmd_decode
`default_nettype wire

/* verif/smbus_master_model.sv */
// link-side model of the external master sending eeprom requests
`timescale 1ns/1ps
`default_nettype none
module smbus_master_model (
   input wire logic link_clk,
   output logic link_frame_start,
   output logic link_block_mode,
   output logic link_byte_valid,
   output logic [7:0] link_byte,
   output logic link_frame_stop
);
   initial begin
      link_frame_start = 1'b0;
      link_block_mode = 1'b0;
      link_byte_valid = 1'b0;
      link_byte = 8'h00;
      link_frame_stop = 1'b0;
   end
   // bytes go out exactly as the caller gives them
   task automatic send(input logic blk, input int n, input logic [55:0] b);
      @(posedge link_clk);
      #2 link_frame_start = 1'b1;
      link_block_mode = blk;
      for (int i = 0; i < n; i++) begin
         @(posedge link_clk);
         #2 link_frame_start = 1'b0;
         link_byte_valid = 1'b1;
         link_byte = b[55-8*i -: 8];
      end
      @(posedge link_clk);
      #2 link_byte_valid = 1'b0;
      link_byte = ~link_byte;
      link_frame_stop = 1'b1;
      @(posedge link_clk);
      #2 link_frame_stop = 1'b0;
   endtask : send
endmodule : smbus_master_model
`default_nettype wire

/* verif/eeprom_cmd_decode_sva.sv */
// port assertions for the eeprom command decode
`timescale 1ns/1ps
`default_nettype none
module eeprom_cmd_decode_sva (
   input wire logic core_clk,
   input wire logic link_clk,
   input wire logic rst_n,
   input wire logic link_reply_valid,
   input wire logic [7:0] link_reply_len,
   input wire logic [7:0] link_reply_cmd,
   input wire logic link_frame_bad,
   input wire logic sts_clear_missing_ack,
   input wire logic sts_clear_framing,
   input wire logic ee_req,
   input wire logic ee_nack,
   input wire logic ee_framing,
   input wire logic missing_ack_flag,
   input wire logic framing_fault_flag
);
   req_pulse_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      ee_req |=> !ee_req) else $error("ee_req longer than one cycle");
   ack_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      ee_nack |=> missing_ack_flag) else $error("missing-ack flag not set");
   ack_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(missing_ack_flag) |-> $past(ee_nack)) else $error("missing-ack flag set without nack");
   ack_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      sts_clear_missing_ack && !ee_nack |=> !missing_ack_flag) else $error("missing-ack flag not cleared");
   frm_set_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      ee_framing |=> framing_fault_flag) else $error("framing flag not set");
   frm_cause_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(framing_fault_flag) |-> $past(ee_framing)) else $error("framing flag set without fault");
   frm_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      sts_clear_framing && !ee_framing |=> !framing_fault_flag) else $error("framing flag not cleared");
   reply_len_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      link_reply_valid |-> link_reply_len == 8'h02) else $error("reply length wrong");
   reply_cmd_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      link_reply_valid |-> link_reply_cmd[0] && (link_reply_cmd & 8'hD4) == 8'h00) else $error("reply cmd wrong");
   bad_pulse_a: assert property (@(posedge link_clk) disable iff (!rst_n)
      link_frame_bad |=> !link_frame_bad) else $error("frame_bad longer than one cycle");
endmodule : eeprom_cmd_decode_sva
bind eeprom_cmd_decode eeprom_cmd_decode_sva eeprom_cmd_decode_sva_inst (.core_clk, .link_clk, .rst_n,
   .link_reply_valid, .link_reply_len, .link_reply_cmd, .link_frame_bad, .sts_clear_missing_ack,
   .sts_clear_framing, .ee_req, .ee_nack, .ee_framing, .missing_ack_flag, .framing_fault_flag);
`default_nettype wire

/* verif/tb.sv */
// self-checking bench for the eeprom command decode
`timescale 1ns/1ps
`default_nettype none
module tb;
   import eeprom_cmd_pkg::*;
   logic core_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
   logic link_frame_start, link_block_mode, link_byte_valid, link_frame_stop;
   logic [7:0] link_byte, link_reply_len, link_reply_cmd, link_reply_data;
   logic link_reply_valid, link_frame_bad, link_busy, ee_req, ee_write, missing_ack_flag, framing_fault_flag;
   logic [6:0] default_memory_device_address = 7'h50, ee_dev_addr;
   logic sts_clear_missing_ack = 1'b0, sts_clear_framing = 1'b0;
   logic ee_done = 1'b0, ee_nack = 1'b0, ee_framing = 1'b0;
   logic [7:0] ee_rdata = 8'h00, ee_wdata;
   logic [15:0] ee_offset;
   logic hit;
   int error_cnt = 0, total_checks = 0, bad_cnt = 0, req_cnt = 0, busy_cnt = 0, cyc = 0;
   eeprom_cmd_decode eeprom_cmd_decode_inst (.core_clk, .rst_n, .link_clk, .link_frame_start, .link_block_mode,
      .link_byte_valid, .link_byte, .link_frame_stop, .link_reply_valid, .link_reply_len, .link_reply_cmd,
      .link_reply_data, .link_frame_bad, .link_busy, .default_memory_device_address, .sts_clear_missing_ack,
      .sts_clear_framing, .ee_req, .ee_write, .ee_dev_addr, .ee_offset, .ee_wdata, .ee_done, .ee_rdata,
      .ee_nack, .ee_framing, .missing_ack_flag, .framing_fault_flag);
   smbus_master_model smbus_master_model_inst (.link_clk, .link_frame_start, .link_block_mode,
      .link_byte_valid, .link_byte, .link_frame_stop);
   always #25 core_clk = ~core_clk;
   always #24 link_clk = ~link_clk;
   always @(posedge link_clk) if (link_frame_bad === 1'b1) bad_cnt++;
   always @(posedge link_clk) if (link_busy === 1'b1) busy_cnt++;
   always @(posedge core_clk) begin
      if (ee_req === 1'b1) req_cnt++;
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic give_verdict();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   task automatic wait_req();
      hit = 1'b0;
      repeat (60) begin
         @(posedge core_clk);
         #1;
         if (ee_req === 1'b1) begin
            hit = 1'b1;
            break;
         end
      end
      chk("ee_req", 16'h0001, {15'h0000, hit});
   endtask : wait_req
   task automatic wait_reply(input int lim);
      hit = 1'b0;
      repeat (lim) begin
         @(posedge link_clk);
         #1;
         if (link_reply_valid === 1'b1) begin
            hit = 1'b1;
            break;
         end
      end
   endtask : wait_reply
   task automatic pulse(ref logic s);
      @(posedge core_clk);
      #2 s = 1'b1;
      @(posedge core_clk);
      #2 s = 1'b0;
      @(posedge core_clk);
      #1;
   endtask : pulse
   task automatic finish_access(input logic [7:0] d);
      ee_rdata = d;
      pulse(ee_done);
   endtask : finish_access
   task automatic t_write();
      smbus_master_model_inst.send(1'b0, 6, 56'h3C_00_A4_34_12_5A_00);
      wait_req();
      chk("busy_seen", 16'h0001, {15'h0000, busy_cnt > 0});
      chk("ee_write", 16'h0001, {15'h0000, ee_write});
      chk("dev_addr", 16'h0050, {9'h000, ee_dev_addr});
      chk("offset", 16'h1234, ee_offset);
      chk("wdata", 16'h005A, {8'h00, ee_wdata});
      finish_access(8'h00);
      wait_reply(40);
      chk("no_reply", 16'h0000, {15'h0000, hit});
      chk("link_busy", 16'h0000, {15'h0000, link_busy});
   endtask : t_write
   task automatic t_read();
      smbus_master_model_inst.send(1'b1, 6, 56'h3C_04_03_A4_78_56_00);
      wait_req();
      chk("ee_write", 16'h0000, {15'h0000, ee_write});
      chk("dev_addr", 16'h0052, {9'h000, ee_dev_addr});
      chk("offset", 16'h5678, ee_offset);
      pulse(ee_nack);
      chk("ack_flag", 16'h0001, {15'h0000, missing_ack_flag});
      finish_access(8'hC3);
      wait_reply(60);
      chk("reply", 16'h0001, {15'h0000, hit});
      chk("reply_len", 16'h0002, {8'h00, link_reply_len});
      chk("reply_cmd", 16'h000B, {8'h00, link_reply_cmd});
      chk("reply_data", 16'h00C3, {8'h00, link_reply_data});
   endtask : t_read
   task automatic t_clear();
      pulse(ee_framing);
      chk("frm_flag", 16'h0001, {15'h0000, framing_fault_flag});
      pulse(sts_clear_framing);
      chk("frm_flag", 16'h0000, {15'h0000, framing_fault_flag});
      chk("ack_flag", 16'h0001, {15'h0000, missing_ack_flag});
      pulse(ee_framing);
      smbus_master_model_inst.send(1'b0, 6, 56'h3C_28_00_01_00_11_00);
      wait_req();
      #50;
      chk("ack_flag", 16'h0000, {15'h0000, missing_ack_flag});
      chk("frm_flag", 16'h0000, {15'h0000, framing_fault_flag});
      finish_access(8'h00);
      pulse(ee_nack);
      pulse(sts_clear_missing_ack);
      chk("ack_flag", 16'h0000, {15'h0000, missing_ack_flag});
   endtask : t_clear
   task automatic t_refuse();
      int b0;
      int r0;
      b0 = bad_cnt;
      r0 = req_cnt;
      smbus_master_model_inst.send(1'b0, 5, 56'h3C_00_A4_34_12_00_00);
      smbus_master_model_inst.send(1'b1, 6, 56'h3C_05_01_A4_34_12_00);
      repeat (40) @(posedge core_clk);
      chk("bad_frames", 16'h0002, 16'(bad_cnt - b0));
      chk("ee_req_cnt", 16'h0000, 16'(req_cnt - r0));
   endtask : t_refuse
   initial begin
      repeat (5) @(posedge core_clk);
      #2 rst_n = 1'b1;
      t_write();
      t_read();
      t_clear();
      t_refuse();
      give_verdict();
   end
endmodule : tb
`default_nettype wire
